// File: rtl/wdcp_regs.svh
`ifndef WDCP_REGS_SVH
`define WDCP_REGS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define WDCP_ADDR_REFRESH 18'h00000
`define WDCP_ADDR_START 18'h00004
`define WDCP_ADDR_CONTROL 18'h00008
`define WDCP_ADDR_PROT 18'h0000C
`define WDCP_ADDR_CLKCTL 18'h00010
`define WDCP_ADDR_PMODE 18'h00014
`define WDCP_ADDR_COUNT 18'h00018
`define WDCP_IDX_OPTION 16'hFFFF
`define WDCP_ADDR_OPTION {`WDCP_IDX_OPTION, 2'h0}

// ****************************************
// field positions
// ****************************************
`define WDCP_OPT_AUTO_BIT 0
`define WDCP_OPT_PRESET_BIT 7
`define WDCP_CTL_PSEL_BIT 7
`define WDCP_CTL_RUN_BIT 6
`define WDCP_PROT_EN_BIT 7
`define WDCP_CLK_STOPREQ_BIT 0
`define WDCP_CLK_LOSCSTOP_BIT 4
`define WDCP_PM_ACTION_BIT 2

// ****************************************
// values and counts
// ****************************************
`define WDCP_REFRESH_ARM 8'h00
`define WDCP_REFRESH_FIRE 8'hFF
`define WDCP_FULL_UNPROT 15'h7FFF
`define WDCP_FULL_PROT 15'h0FFF
`define WDCP_DIV16_MASK 7'h0F
`define WDCP_DIV128_MASK 7'h7F
`define WDCP_PRESC_ONE 7'h01
`define WDCP_CNT_ONE 15'h0001
`define WDCP_CNT_ZERO 15'h0000
`define WDCP_RESET_BIT 1'b0
`define WDCP_RESET_PRESC 7'h00
`define WDCP_RESET_OPTION 8'hFF
`define WDCP_RESET_WORD 32'h00000000

`endif

// File: rtl/wdcp_pkg.sv
package wdcp_pkg;
  // gray path: init -> stopped -> running
  typedef enum logic [1:0] {
    WDCP_INIT = 2'h0,
    WDCP_STOPPED = 2'h1,
    WDCP_RUNNING = 2'h3
  } wdcp_state_e;
endpackage

// File: rtl/wdcp_sync.sv
`timescale 1ns/1ns
// ****************************************
// three-stage pin synchroniser with rise detect
// ****************************************
module wdcp_sync (
  input wire logic clk, // block clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic async_in, // pin from another domain
  output logic rise // one-cycle pulse on a settled rising edge
);
  logic s1;
  logic s2;
  logic s3;
  logic s_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a new level counts once stages two and three agree
  assign rise = s2 & s3 & ~s_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_prev_q <= 1'b0;
    end else if (ce && (s2 == s3)) begin
      s_prev_q <= s3;
    end
  end
endmodule

// File: rtl/wdcp_top.sv
`timescale 1ns/1ns
`include "wdcp_regs.svh"
module wdcp_top #(
  parameter int CNT_W = 15, // counter width
  parameter int PRESC_W = 7 // prescaler width
) (
  input wire logic pclk, // cpu clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [17:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [7:0] option_boot_byte, // nonvolatile option strap
  input wire logic losc_clk, // low-speed oscillator pin
  input wire logic wait_mode, // system in wait mode
  input wire logic stop_mode, // system in stop mode
  output logic wdt_reset_req, // one-cycle reset request
  output logic wdt_irq, // one-cycle interrupt request
  output logic stop_mode_request, // stop-mode request bit
  output logic low_speed_osc_stop // oscillator stop bit
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (CNT_W != 15) begin : g_bad_cnt
    $error("counter width must be 15");
  end
  if (PRESC_W != 7) begin : g_bad_presc
    $error("prescaler width must be 7");
  end

  // ****************************************
  // state
  // ****************************************
  wdcp_pkg::wdcp_state_e state;
  wdcp_pkg::wdcp_state_e next_state;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] next_counter;
  logic [PRESC_W-1:0] presc;
  logic [7:0] option_q;
  logic prot;
  logic psel_bit;
  logic action;
  logic refresh_armed;
  logic losc_rise;
  logic strap_taken;

  // ****************************************
  // apb decode
  // ****************************************
  function automatic logic hit(input logic [17:0] a, input logic [17:0] ref_a);
    hit = (a == ref_a);
  endfunction

  wire apb_wr = ce & psel & penable & pwrite;
  wire hit_refresh = hit(paddr, `WDCP_ADDR_REFRESH);
  wire hit_start = hit(paddr, `WDCP_ADDR_START);
  wire hit_control = hit(paddr, `WDCP_ADDR_CONTROL);
  wire hit_prot = hit(paddr, `WDCP_ADDR_PROT);
  wire hit_clkctl = hit(paddr, `WDCP_ADDR_CLKCTL);
  wire hit_pmode = hit(paddr, `WDCP_ADDR_PMODE);
  wire hit_count = hit(paddr, `WDCP_ADDR_COUNT);
  wire hit_option = hit(paddr, `WDCP_ADDR_OPTION);
  wire mapped = hit_refresh | hit_start | hit_control | hit_prot | hit_clkctl
    | hit_pmode | hit_count | hit_option;
  wire wr_refresh = apb_wr & hit_refresh;
  wire wr_start = apb_wr & hit_start;
  wire wr_control = apb_wr & hit_control;
  wire wr_prot = apb_wr & hit_prot;
  wire wr_clkctl = apb_wr & hit_clkctl;
  wire wr_pmode = apb_wr & hit_pmode;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ****************************************
  // counting conditions
  // ****************************************
  wire running = (state == wdcp_pkg::WDCP_RUNNING);
  wire refresh_hit = wr_refresh & refresh_armed
    & (pwdata[7:0] == `WDCP_REFRESH_FIRE);
  wire prot_set = wr_prot & pwdata[`WDCP_PROT_EN_BIT] & ~prot;
  wire preset_prot = ~option_q[`WDCP_OPT_PRESET_BIT];
  wire strap_load = ce & strap_taken & (state == wdcp_pkg::WDCP_INIT);
  wire preset_load = strap_load & preset_prot;
  // halt when unprotected and in low-power modes
  wire presc_run = running & ~prot & ~wait_mode & ~stop_mode;
  wire [PRESC_W-1:0] div_mask = psel_bit ? `WDCP_DIV128_MASK : `WDCP_DIV16_MASK;
  wire presc_tick = presc_run & ((presc & div_mask) == div_mask);
  // one decrement per oscillator edge, wait mode ignored
  wire prot_tick = running & prot & losc_rise;
  wire dec = presc_tick | prot_tick;
  wire underflow = dec & (counter == `WDCP_CNT_ZERO);
  wire [CNT_W-1:0] full_value = prot ? `WDCP_FULL_PROT : `WDCP_FULL_UNPROT;
  wire under_reset = underflow & (prot | action);
  wire under_irq = underflow & ~prot & ~action;

  // ****************************************
  // oscillator pin synchroniser
  // ****************************************
  wdcp_sync u_losc_sync (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .async_in(losc_clk),
    .rise(losc_rise)
  );

  // ****************************************
  // next counter value
  // ****************************************
  always_comb begin
    next_counter = counter;
    if (prot_set || preset_load) begin
      next_counter = `WDCP_FULL_PROT;
    end else if (refresh_hit) begin
      next_counter = full_value;
    end else if (underflow) begin
      next_counter = full_value;
    end else if (dec) begin
      next_counter = counter - `WDCP_CNT_ONE;
    end
  end

  // ****************************************
  // start state machine
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      wdcp_pkg::WDCP_INIT: begin
        if (option_q[`WDCP_OPT_AUTO_BIT]) begin
          next_state = wdcp_pkg::WDCP_STOPPED;
        end else begin
          next_state = wdcp_pkg::WDCP_RUNNING;
        end
      end
      wdcp_pkg::WDCP_STOPPED: begin
        if (wr_start) begin
          next_state = wdcp_pkg::WDCP_RUNNING;
        end
      end
      wdcp_pkg::WDCP_RUNNING: begin
        next_state = wdcp_pkg::WDCP_RUNNING;
      end
      default: begin
        next_state = wdcp_pkg::WDCP_INIT;
      end
    endcase
  end

  // ****************************************
  // strap capture, state, counter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken <= `WDCP_RESET_BIT;
      option_q <= `WDCP_RESET_OPTION;
    end else if (ce && !strap_taken) begin
      strap_taken <= 1'b1;
      option_q <= option_boot_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= wdcp_pkg::WDCP_INIT;
      counter <= `WDCP_FULL_UNPROT;
    end else if (ce && strap_taken) begin
      state <= next_state;
      counter <= next_counter;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= `WDCP_RESET_PRESC;
    end else if (ce && presc_run) begin
      presc <= presc + `WDCP_PRESC_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_armed <= `WDCP_RESET_BIT;
    end else if (wr_refresh) begin
      refresh_armed <= (pwdata[7:0] == `WDCP_REFRESH_ARM);
    end
  end

  // ****************************************
  // control bits
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot <= `WDCP_RESET_BIT;
      action <= `WDCP_RESET_BIT;
      low_speed_osc_stop <= `WDCP_RESET_BIT;
      stop_mode_request <= `WDCP_RESET_BIT;
      psel_bit <= `WDCP_RESET_BIT;
    end else if (preset_load) begin
      prot <= 1'b1;
      action <= 1'b1;
      low_speed_osc_stop <= 1'b0;
    end else if (prot_set) begin
      prot <= 1'b1;
      action <= 1'b1;
      low_speed_osc_stop <= 1'b0;
    end else begin
      if (wr_control) begin
        psel_bit <= pwdata[`WDCP_CTL_PSEL_BIT];
      end
      if (wr_pmode && !prot) begin
        action <= pwdata[`WDCP_PM_ACTION_BIT];
      end
      if (wr_clkctl) begin
        if (!(prot && pwdata[`WDCP_CLK_STOPREQ_BIT])) begin
          stop_mode_request <= pwdata[`WDCP_CLK_STOPREQ_BIT];
        end
        if (!(prot && pwdata[`WDCP_CLK_LOSCSTOP_BIT])) begin
          low_speed_osc_stop <= pwdata[`WDCP_CLK_LOSCSTOP_BIT];
        end
      end
    end
  end

  // ****************************************
  // underflow outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_reset_req <= `WDCP_RESET_BIT;
      wdt_irq <= `WDCP_RESET_BIT;
    end else if (ce) begin
      wdt_reset_req <= under_reset & strap_taken;
      wdt_irq <= under_irq & strap_taken;
    end
  end

  // ****************************************
  // read data, captured in the setup cycle
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `WDCP_RESET_WORD;
    if (hit_control) begin
      rd_mux[`WDCP_CTL_PSEL_BIT] = psel_bit;
      rd_mux[`WDCP_CTL_RUN_BIT] = running;
    end
    if (hit_prot) begin
      rd_mux[`WDCP_PROT_EN_BIT] = prot;
    end
    if (hit_clkctl) begin
      rd_mux[`WDCP_CLK_STOPREQ_BIT] = stop_mode_request;
      rd_mux[`WDCP_CLK_LOSCSTOP_BIT] = low_speed_osc_stop;
    end
    if (hit_pmode) begin
      rd_mux[`WDCP_PM_ACTION_BIT] = action;
    end
    if (hit_count) begin
      rd_mux[CNT_W-1:0] = counter;
    end
    if (hit_option) begin
      rd_mux[7:0] = option_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `WDCP_RESET_WORD;
    end else if (ce && psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_REFRESH: assert property (refresh_hit && ce && strap_taken && !prot_set
    |=> counter == $past(full_value)) else $error("refresh did not reload");
  AST_PRESC_KEEP: assert property (refresh_hit && presc_run && ce
    |=> presc == $past(presc) + `WDCP_PRESC_ONE) else $error("refresh disturbed prescaler");
  AST_PROT_LOAD: assert property (prot_set && ce && strap_taken
    |=> counter == `WDCP_FULL_PROT && prot) else $error("protection load missing");
  AST_PROT_SIDE: assert property (prot_set
    |=> !low_speed_osc_stop && action) else $error("protection side effects missing");
  AST_STOP_LOCK: assert property (prot && wr_clkctl && pwdata[`WDCP_CLK_STOPREQ_BIT]
    && !stop_mode_request |=> !stop_mode_request) else $error("stop request accepted");
  AST_OSC_LOCK: assert property (prot && wr_clkctl && pwdata[`WDCP_CLK_LOSCSTOP_BIT]
    |=> !low_speed_osc_stop) else $error("oscillator stop accepted");
  AST_UNDER_RESET: assert property (underflow && prot && ce && strap_taken
    |=> wdt_reset_req && !wdt_irq) else $error("protected underflow not a reset");
  AST_UNDER_IRQ: assert property (underflow && !prot && !action && ce && strap_taken
    |=> wdt_irq && !wdt_reset_req) else $error("interrupt missing on underflow");
  AST_HALT: assert property (!prot && running && (wait_mode || stop_mode) && !apb_wr
    |=> counter == $past(counter)) else $error("counter moved in low-power mode");
  AST_WAIT_COUNT: assert property (prot && wait_mode && prot_tick && !apb_wr && ce
    && counter != `WDCP_CNT_ZERO |=> counter == $past(counter) - `WDCP_CNT_ONE)
    else $error("protected count halted");
  AST_AUTOSTART: assert property (state == wdcp_pkg::WDCP_INIT && strap_taken && ce
    && !option_q[`WDCP_OPT_AUTO_BIT] |=> running) else $error("auto-start failed");

  COV_REFRESH: cover property (refresh_hit);
  COV_PROT_UNDER: cover property (underflow && prot);
  COV_IRQ: cover property (wdt_irq);
  COV_START: cover property (wr_start && state == wdcp_pkg::WDCP_STOPPED);
endmodule

// File: sim/wdcp_top_tb.sv
`timescale 1ns/1ns
`include "wdcp_regs.svh"
module wdcp_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] opt = 8'h81;
  logic losc_clk = 1'b0;
  logic losc_en = 1'b0;
  logic [2:0] losc_div = 3'h0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic wdt_reset_req;
  logic wdt_irq;
  logic stop_mode_request;
  logic low_speed_osc_stop;
  logic [31:0] rd;
  logic [31:0] c0;
  logic err;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_irq = 0;
  int n;

  wdcp_top u_wdcp_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .option_boot_byte(opt), .losc_clk(losc_clk),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .wdt_reset_req(wdt_reset_req),
    .wdt_irq(wdt_irq), .stop_mode_request(stop_mode_request),
    .low_speed_osc_stop(low_speed_osc_stop));

  always #5 pclk = ~pclk;

  // ****************************************
  // oscillator stand-in, pulse counting and timeout
  // ****************************************
  always @(posedge pclk) begin
    cycles++;
    losc_div <= losc_div + 3'h1;
    losc_clk <= losc_en & losc_div[2];
    if (wdt_irq === 1'b1) begin
      n_irq++;
    end
    if (cycles > 60000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdreg(input logic [17:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  task automatic pwait(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_in(input string nm, input logic [31:0] lo, input logic [31:0] hi,
    input logic [31:0] g);
    n_tests++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      miscompares++;
      $display("BAD %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask

  task automatic do_reset(input logic [7:0] o);
    presetn <= 1'b0;
    opt <= o;
    pwait(10);
    presetn <= 1'b1;
    pwait(3);
  endtask

  initial begin
    @(posedge pclk);
    do_reset(8'h81);
    // ****************************************
    // stopped start, strap, start writes, unmapped
    // ****************************************
    rdreg(`WDCP_ADDR_CONTROL);
    chk("running", 32'h00000000, rd & 32'h00000040);
    rdreg(`WDCP_ADDR_COUNT);
    c0 = rd;
    pwait(200);
    rdreg(`WDCP_ADDR_COUNT);
    chk("held count", c0, rd);
    wr(`WDCP_ADDR_OPTION, 32'h00000000);
    rdreg(`WDCP_ADDR_OPTION);
    chk("option byte", 32'h00000081, rd);
    rdreg(`WDCP_ADDR_PROT);
    chk("prot off", 32'h00000000, rd & 32'h00000080);
    rdreg(18'h00100);
    chk("unmapped err", 32'h00000001, {31'h0, err});
    chk("unmapped data", 32'h00000000, rd);
    chk("ready", 32'h00000001, {31'h0, pready});
    for (int i = 0; i < 2; i++) begin
      wr(`WDCP_ADDR_START, 32'h0000005A * i);
      rdreg(`WDCP_ADDR_CONTROL);
      chk("started", 32'h00000040, rd & 32'h00000040);
    end
    $display("test start done");
    // ****************************************
    // prescaler ratios, halt in low-power modes
    // ****************************************
    for (int i = 0; i < 2; i++) begin
      wr(`WDCP_ADDR_CONTROL, 32'h00000080 * i);
      rdreg(`WDCP_ADDR_COUNT);
      c0 = rd;
      pwait(160 + 1120 * i);
      rdreg(`WDCP_ADDR_COUNT);
      chk_in("prescaled", c0 - 11, c0 - 9, rd);
    end
    wr(`WDCP_ADDR_CONTROL, 32'h00000000);
    ce <= 1'b0;
    wr(`WDCP_ADDR_CONTROL, 32'h00000080);
    ce <= 1'b1;
    rdreg(`WDCP_ADDR_CONTROL);
    chk("ce frozen", 32'h00000000, rd & 32'h00000080);
    for (int m = 0; m < 2; m++) begin
      wait_mode <= (m == 0);
      stop_mode <= (m == 1);
      pwait(2);
      rdreg(`WDCP_ADDR_COUNT);
      c0 = rd;
      pwait(300);
      rdreg(`WDCP_ADDR_COUNT);
      chk("halted", c0, rd);
    end
    wait_mode <= 1'b0;
    stop_mode <= 1'b0;
    pwait(160);
    rdreg(`WDCP_ADDR_COUNT);
    chk_in("resumed", c0 - 11, c0 - 9, rd);
    wr(`WDCP_ADDR_REFRESH, 32'h00000000);
    wr(`WDCP_ADDR_CONTROL, 32'h00000000);
    wr(`WDCP_ADDR_REFRESH, 32'h000000FF);
    rdreg(`WDCP_ADDR_COUNT);
    chk_in("refresh", 32'h00007FFE, 32'h00007FFF, rd);
    pwait(100);
    rdreg(`WDCP_ADDR_COUNT);
    c0 = rd;
    wr(`WDCP_ADDR_REFRESH, 32'h00000000);
    wr(`WDCP_ADDR_REFRESH, 32'h00000055);
    wr(`WDCP_ADDR_REFRESH, 32'h000000FF);
    rdreg(`WDCP_ADDR_COUNT);
    chk_in("disarmed", 32'h00000000, c0, rd);
    wr(`WDCP_ADDR_CLKCTL, 32'h00000011);
    chk("clk bits", 32'h00000003, {30'h0, stop_mode_request, low_speed_osc_stop});
    wr(`WDCP_ADDR_PMODE, 32'h00000000);
    rdreg(`WDCP_ADDR_PMODE);
    chk("action clear", 32'h00000000, rd & 32'h00000004);
    $display("test unprotected done");
    // ****************************************
    // protection enable and its side effects
    // ****************************************
    wr(`WDCP_ADDR_PROT, 32'h00000080);
    rdreg(`WDCP_ADDR_COUNT);
    chk("prot load", 32'h00000FFF, rd);
    rdreg(`WDCP_ADDR_CLKCTL);
    chk("osc on", 32'h00000000, rd & 32'h00000010);
    rdreg(`WDCP_ADDR_PMODE);
    chk("action", 32'h00000004, rd & 32'h00000004);
    wr(`WDCP_ADDR_CLKCTL, 32'h00000000);
    wr(`WDCP_ADDR_CLKCTL, 32'h00000011);
    chk("clk pins", 32'h00000000, {30'h0, stop_mode_request, low_speed_osc_stop});
    wr(`WDCP_ADDR_PMODE, 32'h00000000);
    wr(`WDCP_ADDR_PROT, 32'h00000000);
    rdreg(`WDCP_ADDR_PMODE);
    chk("action kept", 32'h00000004, rd & 32'h00000004);
    rdreg(`WDCP_ADDR_PROT);
    chk("prot sticky", 32'h00000080, rd & 32'h00000080);
    $display("test protection done");
    // ****************************************
    // oscillator counting, refresh, underflow
    // ****************************************
    n_irq = 0;
    losc_en <= 1'b1;
    wait_mode <= 1'b1;
    pwait(20);
    rdreg(`WDCP_ADDR_COUNT);
    c0 = rd;
    pwait(80);
    rdreg(`WDCP_ADDR_COUNT);
    chk_in("osc count", c0 - 11, c0 - 9, rd);
    wr(`WDCP_ADDR_REFRESH, 32'h00000000);
    wr(`WDCP_ADDR_REFRESH, 32'h000000FF);
    rdreg(`WDCP_ADDR_COUNT);
    chk_in("prot refresh", 32'h00000FFD, 32'h00000FFF, rd);
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    chk("underflow reset", 32'h00000001, {31'h0, wdt_reset_req});
    pwait(2);
    rdreg(`WDCP_ADDR_COUNT);
    chk_in("reload", 32'h00000FFD, 32'h00000FFF, rd);
    chk("no irq", 32'h00000000, n_irq);
    wait_mode <= 1'b0;
    losc_en <= 1'b0;
    $display("test underflow done");
    // ****************************************
    // protected and running straight from reset
    // ****************************************
    do_reset(8'h00);
    rdreg(`WDCP_ADDR_PROT);
    chk("preset prot", 32'h00000080, rd & 32'h00000080);
    rdreg(`WDCP_ADDR_CONTROL);
    chk("auto run", 32'h00000040, rd & 32'h00000040);
    rdreg(`WDCP_ADDR_COUNT);
    chk("preset load", 32'h00000FFF, rd);
    rdreg(`WDCP_ADDR_PMODE);
    chk("preset action", 32'h00000004, rd & 32'h00000004);
    $display("test preset done");
    finish_test();
  end
endmodule
